// file: rtl/esh_pkg.sv
// Package with constants and types for the emergency signal handler
// Functional notes
// R01 - The external stop input comes from outside and a low level asks the controller for an emergency.
// R02 - The emergency output is driven low whenever the controller core or the logic controller reports an error.
// R03 - A low emergency request from the logic controller halts axes and spindle and raises its error indication.
// R04 - The alarm flag toward the logic controller is driven low whenever an alarm or emergency exists.
// R05 - An emergency starts when either the external stop or the logic controller request is active.
// R06 - An internal malfunction or an external device fault also halts axes and spindle and raises an error.
// R07 - Any emergency cause drives both the emergency output and the alarm flag active.
// R08 - Both the emergency output and the alarm flag are released once no cause remains.
// R09 - At the start of each scan all physical inputs are copied to the input image, bit one holding the stop input.
// R10 - Before each scan runs the controller output image, alarm mark included, is refreshed.
// R11 - After each scan outputs follow the output image, and the emergency output is active if output bit one or the alarm is.
// R12 - The logic controller program must react to the stop input and alarm and drive its emergency outputs as needed.
// R13 - The logic controller program asks for an emergency through the output flag feeding the request input.
// R14 - Emergency inputs are synchronised before use and the emergency output only changes at the end of a scan.
package esh_pkg;

  // Scan cycle phases
  typedef enum logic [1:0] {
    ESH_IDLE    = 2'b00,
    ESH_SAMPLE  = 2'b01,
    ESH_EXECUTE = 2'b10,
    ESH_UPDATE  = 2'b11
  } esh_phase_t;

  // Bit positions in the images
  localparam int ESH_STOP_BIT    = 1;
  localparam int ESH_OUT_EMG_BIT = 1;

  // Reset levels of active-low lines: released
  localparam logic ESH_RELEASED_N = 1'b1;

endpackage : esh_pkg

// file: rtl/esh_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
module esh_sync
  import esh_pkg::*;
#(
  parameter int WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("esh_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : esh_sync

// file: rtl/esh_emergency_handler.sv
// Emergency signal handler top: cause collection, alarm flag and scan-synchronous emergency output
module esh_emergency_handler
  import esh_pkg::*;
#(
  parameter int IN_WIDTH  = 16,
  parameter int OUT_WIDTH = 16,
  parameter int CNC_WIDTH = 16
) (
  // Clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // External safety chain pins
  input  wire logic                 ext_stop_n,
  output logic                      emerg_out_n,
  // Fault sources
  input  wire logic                 core_fault,
  input  wire logic                 ext_dev_fault,
  input  wire logic                 plc_fault,
  // Logic controller flag exchange
  input  wire logic                 logic_emerg_request_n,
  output logic                      alarm_n,
  // Motion halt and error indications
  output logic                      motion_halt,
  output logic                      err_ext_stop,
  output logic                      err_plc_request,
  output logic                      err_internal,
  // Scan cycle control
  input  wire logic                 scan_start,
  input  wire logic                 scan_done,
  output logic [1:0]                scan_phase,
  // Physical inputs and input image
  input  wire logic [IN_WIDTH-1:0]  phys_in,
  output logic [IN_WIDTH-1:0]       in_image,
  // Controller output image toward the logic controller
  input  wire logic [CNC_WIDTH-1:0] cnc_out,
  output logic [CNC_WIDTH-1:0]      cnc_image,
  output logic                      alarm_mark_n,
  // Output image from the program and physical outputs
  input  wire logic [OUT_WIDTH-1:0] out_image,
  output logic [OUT_WIDTH-1:0]      phys_out
);

  initial begin
    if (IN_WIDTH <= ESH_STOP_BIT) $error("esh_emergency_handler: IN_WIDTH too small");
    if (OUT_WIDTH <= ESH_OUT_EMG_BIT) $error("esh_emergency_handler: OUT_WIDTH too small");
    if (CNC_WIDTH < 1) $error("esh_emergency_handler: CNC_WIDTH must be at least 1");
  end

  // Synchronised pins: stop, request, fault lines, then the physical input bus
  localparam int NSYNC = 5 + IN_WIDTH;
  localparam logic [NSYNC-1:0] SYNC_RST = {{IN_WIDTH{1'b0}}, 5'b00011};

  logic [NSYNC-1:0] sync_raw;
  logic [NSYNC-1:0] sync_val;

  assign sync_raw = {phys_in, plc_fault, ext_dev_fault, core_fault,
                     logic_emerg_request_n, ext_stop_n};

  // Every asynchronous input passes two flops before use
  esh_sync #(
    .WIDTH   (NSYNC),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (sync_raw),
    .sync_out (sync_val)
  ); // see R14

  logic                stop_s_n;
  logic                req_s_n;
  logic                core_s;
  logic                dev_s;
  logic                plc_s;
  logic [IN_WIDTH-1:0] phys_s;

  assign stop_s_n = sync_val[0];
  assign req_s_n  = sync_val[1];
  assign core_s   = sync_val[2];
  assign dev_s    = sync_val[3];
  assign plc_s    = sync_val[4];
  assign phys_s   = sync_val[NSYNC-1:5];

  // Cause collection; the stop pin is driven low by the outside chain
  logic cause_stop;
  logic cause_req;
  logic cause_int;
  logic any_cause;

  assign cause_stop = ~stop_s_n;             // see R01 see R05
  assign cause_req  = ~req_s_n;              // see R03 see R05
  assign cause_int  = core_s | dev_s;        // see R06
  assign any_cause  = cause_stop | cause_req | cause_int | plc_s; // see R02 see R07

  // Halt and error indications follow the causes and clear when they go
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      motion_halt     <= 1'b0;
      err_ext_stop    <= 1'b0;
      err_plc_request <= 1'b0;
      err_internal    <= 1'b0;
    end else if (clk_en) begin
      motion_halt     <= any_cause;          // see R03 see R05 see R06
      err_ext_stop    <= cause_stop;         // see R05
      err_plc_request <= cause_req;          // see R03
      err_internal    <= cause_int | plc_s;  // see R06
    end
  end

  // Alarm flag is immediate; released as soon as no cause remains
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm_n <= ESH_RELEASED_N;
    end else if (clk_en) begin
      alarm_n <= ~any_cause;                 // see R04 see R07 see R08
    end
  end

  // Scan phase sequencing
  esh_phase_t phase_q;
  esh_phase_t phase_d;

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      ESH_IDLE:    if (scan_start) phase_d = ESH_SAMPLE;
      ESH_SAMPLE:  phase_d = ESH_EXECUTE;
      ESH_EXECUTE: if (scan_done) phase_d = ESH_UPDATE;
      ESH_UPDATE:  phase_d = ESH_IDLE;
      default:     phase_d = ESH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= ESH_IDLE;
    end else if (clk_en) begin
      phase_q <= phase_d;
    end
  end

  logic sample_pt;
  logic update_pt;

  assign sample_pt = (phase_q == ESH_SAMPLE);
  assign update_pt = (phase_q == ESH_UPDATE);

  // Input image and controller image taken before execution begins
  logic [IN_WIDTH-1:0] in_image_d;

  always_comb begin
    in_image_d = phys_s;
    in_image_d[ESH_STOP_BIT] = stop_s_n;     // see R09
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_image     <= '0;
      cnc_image    <= '0;
      alarm_mark_n <= ESH_RELEASED_N;
      scan_phase   <= 2'h0;
    end else if (clk_en) begin
      scan_phase <= phase_d;
      if (sample_pt) begin
        in_image     <= in_image_d;          // see R09
        cnc_image    <= cnc_out;             // see R10
        alarm_mark_n <= alarm_n;             // see R10
      end
    end
  end

  // Physical outputs; the emergency line is forced by output bit one or the alarm mark.
  // Both are active low, so an AND of the two levels is an OR of their active states.
  logic emerg_d_n;
  logic [OUT_WIDTH-1:0] phys_out_d;

  assign emerg_d_n = out_image[ESH_OUT_EMG_BIT] & alarm_mark_n;   // see R11

  always_comb begin
    phys_out_d = out_image;
    phys_out_d[ESH_OUT_EMG_BIT] = emerg_d_n; // see R11
  end

  // The pin stays stale during a scan; a cause reaches it at the update of the first scan whose sample point sees the alarm flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phys_out    <= {OUT_WIDTH{1'b1}};
      emerg_out_n <= ESH_RELEASED_N;
    end else if (clk_en && update_pt) begin
      phys_out    <= phys_out_d;             // see R11
      emerg_out_n <= emerg_d_n;              // see R02 see R08 see R14
    end
  end

endmodule : esh_emergency_handler

// file: verification/esh_emergency_monitor.sv
// Port-level checker for the emergency signal handler
module esh_emergency_monitor
  import esh_pkg::*;
#(
  parameter int OUT_WIDTH = 16
) (
  // Clock and control
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 clk_en,
  // Causes
  input wire logic                 ext_stop_n,
  input wire logic                 logic_emerg_request_n,
  input wire logic                 core_fault,
  input wire logic                 ext_dev_fault,
  input wire logic                 plc_fault,
  // Indications and scan
  input wire logic                 alarm_n,
  input wire logic                 motion_halt,
  input wire logic                 err_ext_stop,
  input wire logic                 err_internal,
  input wire logic                 scan_start,
  input wire logic [1:0]           scan_phase,
  input wire logic                 alarm_mark_n,
  input wire logic [OUT_WIDTH-1:0] out_image,
  input wire logic [OUT_WIDTH-1:0] phys_out,
  input wire logic                 emerg_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Causes as the handler combines them
  wire fault     = core_fault || ext_dev_fault || plc_fault;
  wire any_cause = !ext_stop_n || !logic_emerg_request_n || fault;
  // Three edges cover both synchroniser stages plus the output register
  sequence s_cause_held; (any_cause && clk_en)[*3]; endsequence
  sequence s_clear_held; (!any_cause && clk_en)[*3]; endsequence
  sequence s_scan_enter; scan_phase == 2'h0 && scan_start && clk_en ##1 clk_en; endsequence
  a_alarm_on_cause: assert property (s_cause_held |=> !alarm_n && motion_halt)
    else $error("alarm or halt missing while a cause is held");
  a_alarm_release: assert property (s_clear_held |=> alarm_n && !motion_halt)
    else $error("alarm or halt kept after the causes left");
  a_stop_error: assert property ((!ext_stop_n && clk_en)[*3] |=> err_ext_stop)
    else $error("stop error missing");
  a_internal_error: assert property ((fault && clk_en)[*3] |=> err_internal)
    else $error("internal error missing");
  a_emerg_frozen: assert property (scan_phase != 2'h3 |=> $stable(emerg_out_n))
    else $error("emergency output moved outside the end of scan");
  a_emerg_value: assert property ((scan_phase == 2'h3 && clk_en) |=>
    emerg_out_n == ($past(out_image[1]) & alarm_mark_n) && phys_out[1] == emerg_out_n)
    else $error("emergency output not the image bit gated by the mark");
  a_mark_refresh: assert property ((scan_phase == 2'h1 && clk_en) |=> alarm_mark_n == $past(alarm_n))
    else $error("alarm mark not refreshed at scan start");
  a_scan_walk: assert property (s_scan_enter |-> scan_phase == 2'h1 ##1 scan_phase == 2'h2)
    else $error("scan did not pass sample into execute");
endmodule : esh_emergency_monitor

// file: verification/esh_plc_model.sv
// Behavioural logic controller program that runs scans for the handler
module esh_plc_model
  import esh_pkg::*;
(
  // Clock, reset and bench commands
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        want_emerg,
  // Handler side
  input  wire logic [1:0]  scan_phase,
  input  wire logic [15:0] in_image,
  output logic             scan_start,
  output logic             scan_done,
  output logic             logic_emerg_request_n,
  output logic [15:0]      out_image
);
  timeunit 1ns;
  timeprecision 100ps;
  // Program acts on the falling edge so the handler never samples a moving flag
  always_ff @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_start            <= 1'b0;
      scan_done             <= 1'b0;
      logic_emerg_request_n <= 1'b1;
      out_image             <= 16'hFFFF;
    end else begin
      scan_start            <= run;
      scan_done             <= (scan_phase == ESH_EXECUTE); // Shortest program: one execute cycle
      logic_emerg_request_n <= !want_emerg;
      out_image             <= 16'hA5A5 | {14'h0, in_image[ESH_STOP_BIT], 1'b0};
    end
  end
endmodule : esh_plc_model

// file: verification/test_emergency_signal_handler.sv
// Self-checking bench for the emergency signal handler
module test_emergency_signal_handler;
  import esh_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst, clk_en, ext_stop_n, core_fault, ext_dev_fault, plc_fault, run, want_emerg;
  logic        scan_start, scan_done, logic_emerg_request_n, emerg_out_n, alarm_n, motion_halt, alarm_mark_n;
  logic        err_ext_stop, err_plc_request, err_internal;
  logic [1:0]  scan_phase;
  logic [15:0] phys_in, in_image, cnc_out, cnc_image, out_image, phys_out;
  int          n_fail, n_checks;

  esh_emergency_handler esh_emergency_handler_i (.*);
  esh_plc_model         esh_plc_model_i (.*);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : ticks

  // Index 1 goes through the program model, so it lands one cycle later
  task automatic set_cause(input int i, input logic v);
    case (i)
      0: ext_stop_n <= !v;
      1: want_emerg <= v;
      2: core_fault <= v;
      3: ext_dev_fault <= v;
      default: plc_fault <= v;
    endcase
  endtask : set_cause

  task automatic t_causes;
    for (int i = 0; i < 5; i++) begin
      set_cause(i, 1'b1);
      ticks(5);
      chk(alarm_n, 1'b0);
      chk(motion_halt, 1'b1);
      chk({err_ext_stop, err_plc_request, err_internal}, i == 0 ? 3'h4 : i == 1 ? 3'h2 : 3'h1);
      set_cause(i, 1'b0);
      ticks(5);
      chk(alarm_n, 1'b1);
    end
    $display("causes test done");
  endtask : t_causes

  // One full scan with cause c held (negative: none)
  task automatic t_scan(input int c, input logic [15:0] e_in, input logic [15:0] e_out);
    if (c >= 0) set_cause(c, 1'b1);
    ticks(5);
    run <= 1'b1;
    for (int k = 0; k < 20 && scan_phase !== ESH_UPDATE; k++) ticks(1);
    run <= 1'b0;
    ticks(1);
    chk(in_image, e_in);
    chk(cnc_image, 16'h1234);
    chk(alarm_mark_n, c < 0);
    chk(phys_out, e_out);
    chk(emerg_out_n, e_out[1]);
    if (c >= 0) set_cause(c, 1'b0);
    $display("scan test done");
  endtask : t_scan

  task automatic close_out;
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // Whole run is about a hundred cycles
  initial begin
    #5us;
    n_fail++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    ext_stop_n = 1'b1;
    {core_fault, ext_dev_fault, plc_fault} = 3'h0;
    {run, want_emerg} = 2'h0;
    phys_in = 16'h3C5A;
    cnc_out = 16'h1234;
    n_fail = 0;
    n_checks = 0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) rst <= 1'b0;
    chk({emerg_out_n, alarm_n, scan_phase}, 4'hC);
    chk(phys_out, 16'hFFFF);
    t_causes();
    t_scan(-1, 16'h3C5A, 16'hA5A7);
    t_scan(2, 16'h3C5A, 16'hA5A5);
    t_scan(4, 16'h3C5A, 16'hA5A5);
    t_scan(0, 16'h3C58, 16'hA5A5);
    t_scan(-1, 16'h3C5A, 16'hA5A7);
    close_out();
  end
endmodule : test_emergency_signal_handler

bind esh_emergency_handler esh_emergency_monitor #(.OUT_WIDTH(OUT_WIDTH)) esh_emergency_monitor_i (.*);
